// >>> rtl/host_register_space_map.sv
// Host register space map: configuration space, 8K memory window decode with
// burst support, and the serial configuration memory engine.
// Assumes a link core that presents config and memory beats on core_clk and a
// register fabric that answers fab_rdata in the cycle of fab_stb_ff.
`include "host_map_consts.svh"

module host_register_space_map
  import host_map_pkg::*;
#(
  parameter logic [15:0] DEF_VENDOR = 16'h1111, // Arbitrary neutral value.
  parameter logic [15:0] DEF_DEVICE = 16'h2222, // Arbitrary neutral value.
  parameter logic [15:0] DEF_SUBVEN = 16'h3333, // Arbitrary neutral value.
  parameter logic [15:0] DEF_SUBSYS = 16'h4444, // Arbitrary neutral value.
  parameter logic [7:0]  REVISION   = 8'h01     // Arbitrary neutral value.
) (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        cfg_req,
  input  wire logic        cfg_wr,
  input  wire logic [7:0]  cfg_off,
  input  wire logic [31:0] cfg_wdata,
  output logic             cfg_ack_ff,
  output logic [31:0]      cfg_rdata_ff,
  input  wire logic        mem_valid,
  input  wire logic        mem_first,
  input  wire logic        mem_wr,
  input  wire logic [31:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  output logic             mem_ack_ff,
  output logic             mem_miss_ff,
  output logic [7:0]       mem_rdata_ff,
  output logic             fab_stb_ff,
  output logic             fab_wr_ff,
  output logic             fab_global_ff,
  output logic [2:0]       fab_chan_ff,
  output logic [9:0]       fab_off_ff,
  output logic [7:0]       fab_wdata_ff,
  input  wire logic [7:0]  fab_rdata,
  input  wire logic [7:0]  chan_irq,
  input  wire logic        timer_irq,
  input  wire logic        mpio_irq,
  input  wire logic        wake_irq,
  input  wire logic        nv_req,
  input  wire logic        nv_wr,
  input  wire logic [5:0]  nv_addr,
  input  wire logic [15:0] nv_wdata,
  output logic             nv_busy_ff,
  output logic             nv_done_ff,
  output logic [15:0]      nv_rdata_ff,
  output logic             cfg_mem_select,
  output logic             cfg_mem_serial_clock,
  output logic             cfg_mem_data_in,
  input  wire logic        cfg_mem_data_out
);

  localparam logic [4:0] SCK_HALF = 5'(`SCK_HALF_CYC); // Core cycles per half bit.

  // Builds a 25-bit frame: three-bit slot of start bit and two-bit opcode, address, data.
  function automatic logic [24:0] frame(input logic [2:0] op, input logic [5:0] a,
                                        input logic [15:0] d);
    frame = {op, a, d};
  endfunction

  // ****************************************************************
  // Serial configuration memory engine.
  // ****************************************************************
  logic             do_meta_ff;     // First synchroniser stage.
  logic             do_sync_ff;     // Second synchroniser stage.
  logic [4:0]       div_ff,   nxt_div;    // Half-bit divider.
  logic             tick;                 // One-cycle half-bit enable.
  mem_state_t       st_ff,    nxt_st;     // Engine state.
  mem_op_t          op_ff,    nxt_op;     // Current operation.
  logic [24:0]      sr_ff,    nxt_sr;     // Outgoing bits, MSB first.
  logic [15:0]      rd_ff,    nxt_rd;     // Captured incoming bits.
  logic [4:0]       cnt_ff,   nxt_cnt;    // Bits left in frame.
  logic             ph_ff,    nxt_ph;     // Serial clock phase.
  logic [2:0]       idx_ff,   nxt_idx;    // Boot word index.
  logic             pres_ff,  nxt_pres;   // Memory holds valid words.
  logic [5:0]       wa_ff,    nxt_wa;     // Pending write address.
  logic [15:0]      wd_ff,    nxt_wd;     // Pending write data.
  logic [15:0]      id_ff [8];            // Identity and override words.
  logic [15:0]      nxt_id [8];
  logic             nxt_busy, nxt_done, nxt_cs, nxt_sck;
  logic [15:0]      nxt_nvrd;

  assign tick = (div_ff == 5'h00);

  // Chooses the next engine values; ticks pace every serial transition except the select rise on a host request.
  always_comb begin
    nxt_div  = tick ? SCK_HALF - 5'h01 : div_ff - 5'h01;
    nxt_st   = st_ff;
    nxt_op   = op_ff;
    nxt_sr   = sr_ff;
    nxt_rd   = rd_ff;
    nxt_cnt  = cnt_ff;
    nxt_ph   = ph_ff;
    nxt_idx  = idx_ff;
    nxt_pres = pres_ff;
    nxt_wa   = wa_ff;
    nxt_wd   = wd_ff;
    nxt_id   = id_ff;
    nxt_done = 1'b0;
    nxt_nvrd = nv_rdata_ff;
    nxt_cs   = cfg_mem_select;
    nxt_sck  = cfg_mem_serial_clock;
    case (st_ff)
      ST_IDLE: begin
        // Host data access; refused while busy, no strobe is kept.
        if (nv_req) begin
          nxt_st  = ST_FRAME;
          nxt_cs  = 1'b1;
          nxt_ph  = 1'b0;
          nxt_wa  = nv_addr;
          nxt_div = SCK_HALF - 5'h01; // Full low half before the first rise.
          nxt_wd  = nv_wdata;
          nxt_op  = nv_wr ? OP_EWEN : OP_READ;
          nxt_sr  = nv_wr ? {`MEM_OP_EWEN, 16'h0000}
                          : frame(`MEM_OP_READ, nv_addr, 16'h0000);
          nxt_cnt = nv_wr ? `MEM_CMD_BITS : `MEM_FRAME_BITS;
        end
      end
      ST_FRAME: begin
        if (tick) begin
          if (!ph_ff) begin
            nxt_sck = 1'b1;
            nxt_rd  = {rd_ff[14:0], do_sync_ff};
            nxt_ph  = 1'b1;
          end else begin
            nxt_sck = 1'b0;
            nxt_sr  = {sr_ff[23:0], 1'b0};
            nxt_cnt = cnt_ff - 5'h01;
            nxt_ph  = 1'b0;
            if (cnt_ff == 5'h01) begin
              nxt_cs = 1'b0;
              nxt_st = ST_GAP;
            end
          end
        end
      end
      ST_GAP: begin
        if (tick) begin
          nxt_st = ST_IDLE;
          case (op_ff)
            OP_BOOT: begin
              // A blank first word means no memory: defaults stay.
              if (idx_ff == 3'h0) begin
                nxt_pres = (rd_ff != `MEM_BLANK_WORD);
              end
              if (idx_ff == 3'h0 ? (rd_ff != `MEM_BLANK_WORD) : pres_ff) begin
                nxt_id[idx_ff] = rd_ff;
              end
              if (idx_ff != `MEM_BOOT_WORDS) begin
                nxt_idx = idx_ff + 3'h1;
                nxt_st  = ST_FRAME;
                nxt_cs  = 1'b1;
                nxt_sr  = frame(`MEM_OP_READ, {3'h0, idx_ff + 3'h1}, 16'h0000);
                nxt_cnt = `MEM_FRAME_BITS;
              end
            end
            OP_READ: begin
              nxt_nvrd = rd_ff;
              nxt_done = 1'b1;
            end
            OP_EWEN: begin
              nxt_op  = OP_WRITE;
              nxt_st  = ST_FRAME;
              nxt_cs  = 1'b1;
              nxt_sr  = frame(`MEM_OP_WRITE, wa_ff, wd_ff);
              nxt_cnt = `MEM_FRAME_BITS;
            end
            default: begin
              nxt_st = ST_POLL;
              nxt_cs = 1'b1;
            end
          endcase
        end
      end
      ST_POLL: begin
        // Memory signals write completion by driving its output high.
        if (tick && do_sync_ff) begin
          nxt_cs   = 1'b0;
          nxt_done = 1'b1;
          nxt_st   = ST_IDLE;
        end
      end
      default: nxt_st = ST_IDLE;
    endcase
    nxt_busy = (nxt_st != ST_IDLE);
  end

  // Registers the engine; reset starts the boot read of word zero.
  always_ff @(posedge core_clk) begin
    do_meta_ff <= cfg_mem_data_out;
    do_sync_ff <= do_meta_ff;
    if (!rstn) begin
      div_ff               <= SCK_HALF - 5'h01; // Data settles before the first rise.
      st_ff                <= ST_FRAME;
      op_ff                <= OP_BOOT;
      sr_ff                <= frame(`MEM_OP_READ, 6'h00, 16'h0000);
      rd_ff                <= 16'h0000;
      cnt_ff               <= `MEM_FRAME_BITS;
      ph_ff                <= 1'b0;
      idx_ff               <= 3'h0;
      pres_ff              <= 1'b0;
      wa_ff                <= 6'h00;
      wd_ff                <= 16'h0000;
      id_ff                <= '{DEF_VENDOR, DEF_SUBVEN, DEF_DEVICE, DEF_SUBSYS,
                                16'(`CFG_CLASS_RESET >> 8),
                                {8'(`CFG_CLASS_RESET), 8'h00},
                                16'h0000, 16'h0000};
      nv_busy_ff           <= 1'b1;
      nv_done_ff           <= 1'b0;
      nv_rdata_ff          <= 16'h0000;
      cfg_mem_select       <= 1'b1;
      cfg_mem_serial_clock <= 1'b0;
      cfg_mem_data_in      <= 1'b0;
    end else begin
      div_ff               <= nxt_div;
      st_ff                <= nxt_st;
      op_ff                <= nxt_op;
      sr_ff                <= nxt_sr;
      rd_ff                <= nxt_rd;
      cnt_ff               <= nxt_cnt;
      ph_ff                <= nxt_ph;
      idx_ff               <= nxt_idx;
      pres_ff              <= nxt_pres;
      wa_ff                <= nxt_wa;
      wd_ff                <= nxt_wd;
      id_ff                <= nxt_id;
      nv_busy_ff           <= nxt_busy;
      nv_done_ff           <= nxt_done;
      nv_rdata_ff          <= nxt_nvrd;
      cfg_mem_select       <= nxt_cs;
      cfg_mem_serial_clock <= nxt_sck;
      cfg_mem_data_in      <= nxt_cs & nxt_sr[24];
    end
  end

  // ****************************************************************
  // Configuration space.
  // ****************************************************************
  logic [31:`CFG_BAR_LSB] bar_ff, nxt_bar;  // Window base address.
  logic                   men_ff, nxt_men;  // Memory space enable.
  logic [31:0]            nxt_crd;

  // Answers config reads from identity words, command and BAR; takes BAR and command writes.
  always_comb begin
    nxt_bar = bar_ff;
    nxt_men = men_ff;
    nxt_crd = cfg_rdata_ff;
    if (cfg_req) begin
      case (cfg_off)
        `CFG_OFF_ID:     nxt_crd = {id_ff[2], id_ff[0]};
        `CFG_OFF_CMD:    nxt_crd = {30'h0, men_ff, 1'b0};
        `CFG_OFF_CLASS:  nxt_crd = {id_ff[4], id_ff[5][15:8], REVISION};
        `CFG_OFF_BAR:    nxt_crd = {bar_ff, 13'h0000};
        `CFG_OFF_SUBSYS: nxt_crd = {id_ff[3], id_ff[1]};
        `CFG_OFF_SPARE:  nxt_crd = {id_ff[7], id_ff[6]};
        default:         nxt_crd = 32'h00000000;
      endcase
      if (cfg_wr && cfg_off == `CFG_OFF_BAR) begin
        nxt_bar = cfg_wdata[31:`CFG_BAR_LSB];
      end
      if (cfg_wr && cfg_off == `CFG_OFF_CMD) begin
        nxt_men = cfg_wdata[`CFG_CMD_MEM_BIT];
      end
      if (cfg_wr) begin
        nxt_crd = 32'h00000000;
      end
    end
  end

  // Registers configuration state; every request is answered next cycle.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      bar_ff       <= '0;
      men_ff       <= 1'b0;
      cfg_ack_ff   <= 1'b0;
      cfg_rdata_ff <= 32'h00000000;
    end else begin
      bar_ff       <= nxt_bar;
      men_ff       <= nxt_men;
      cfg_ack_ff   <= cfg_req;
      cfg_rdata_ff <= nxt_crd;
    end
  end

  // ****************************************************************
  // Memory window decode and burst tracking.
  // ****************************************************************
  logic [12:0] base_ff, nxt_base;   // Window offset of the burst start.
  logic [8:0]  beat_ff, nxt_beat;   // Beats taken in this burst.
  logic        s1_ff;               // Stage-one beat present.
  logic        s1_int_ff;           // Stage-one hits interrupt sources.
  logic        s1_miss_ff;          // Stage-one beat refused.
  logic [1:0]  s1_isel_ff;          // Interrupt source register select.
  logic [12:0] off;                 // Window offset of this beat.
  logic        hit, in_int, ok;
  logic        nxt_stb, nxt_glb;
  logic [7:0]  int_byte;

  // Offsets the beat inside the burst; the FIFO data port holds still.
  always_comb begin
    nxt_base = base_ff;
    nxt_beat = beat_ff;
    off      = mem_first ? mem_addr[12:0]
             : (base_ff[9:0] == `WIN_DATA_PORT) ? base_ff
             : base_ff + 13'(beat_ff);
    hit      = men_ff && (mem_addr[31:`CFG_BAR_LSB] == bar_ff || !mem_first);
    ok       = hit && (mem_first || beat_ff < `BURST_MAX);
    if (mem_valid) begin
      nxt_base = mem_first ? mem_addr[12:0] : base_ff;
      // A refused first beat parks the count, so its continuations miss too.
      nxt_beat = mem_first ? (ok ? 9'h001 : `BURST_MAX) : (ok ? beat_ff + 9'h001 : beat_ff);
    end
    // Globals live at 0x080 of channel zero's slice.
    nxt_glb = (off[12:`WIN_CHAN_LSB] == 3'h0) && (off[9:0] >= `WIN_GLOBAL_BASE);
    in_int  = nxt_glb && (off[9:2] == 8'(`WIN_INT_BASE >> 2));
    nxt_stb = mem_valid && ok && !in_int;
  end

  // Selects the interrupt source byte named in stage one.
  always_comb begin
    case (s1_isel_ff)
      2'h0:    int_byte = chan_irq;
      2'h1:    int_byte = {5'h00, wake_irq, mpio_irq, timer_irq};
      2'h2:    int_byte = 8'h00;
      default: int_byte = 8'h00;
    endcase
  end

  // Stage one strobes the fabric; stage two returns the answer.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      base_ff       <= 13'h0000;
      beat_ff       <= 9'h000;
      s1_ff         <= 1'b0;
      s1_int_ff     <= 1'b0;
      s1_miss_ff    <= 1'b0;
      s1_isel_ff    <= 2'h0;
      fab_stb_ff    <= 1'b0;
      fab_wr_ff     <= 1'b0;
      fab_global_ff <= 1'b0;
      fab_chan_ff   <= 3'h0;
      fab_off_ff    <= 10'h000;
      fab_wdata_ff  <= 8'h00;
      mem_ack_ff    <= 1'b0;
      mem_miss_ff   <= 1'b0;
      mem_rdata_ff  <= 8'h00;
    end else begin
      base_ff       <= nxt_base;
      beat_ff       <= nxt_beat;
      s1_ff         <= mem_valid;
      s1_int_ff     <= mem_valid && ok && in_int && !mem_wr;
      s1_miss_ff    <= !ok;
      s1_isel_ff    <= off[1:0];
      fab_stb_ff    <= nxt_stb;
      fab_wr_ff     <= nxt_stb && mem_wr;
      fab_global_ff <= nxt_glb;
      fab_chan_ff   <= off[12:`WIN_CHAN_LSB];
      fab_off_ff    <= off[9:0];
      fab_wdata_ff  <= mem_wdata;
      mem_ack_ff    <= s1_ff;
      mem_miss_ff   <= s1_ff && s1_miss_ff;
      // Write beats answer zero; only read strobes return fabric data.
      mem_rdata_ff  <= s1_int_ff ? int_byte : (fab_stb_ff && !fab_wr_ff ? fab_rdata : 8'h00);
    end
  end

endmodule

// >>> rtl/host_map_consts.svh
// Constants of the host register space map: offsets, reset values, timing.
// Assumes inclusion by bare name from the package and the top module.
`ifndef HOST_MAP_CONSTS_SVH
`define HOST_MAP_CONSTS_SVH

// ****************************************************************
// Configuration space offsets (byte addresses, dword aligned).
// ****************************************************************
`define CFG_OFF_ID        8'h00
`define CFG_OFF_CMD       8'h04
`define CFG_OFF_CLASS     8'h08
`define CFG_OFF_BAR       8'h10
`define CFG_OFF_SUBSYS    8'h2C
`define CFG_OFF_SPARE     8'h40
`define CFG_CMD_MEM_BIT   1
`define CFG_BAR_LSB       13
`define CFG_CLASS_RESET   24'h070002

// ****************************************************************
// Memory window layout inside the 8K region.
// ****************************************************************
`define WIN_CHAN_LSB      10
`define WIN_GLOBAL_BASE   10'h080
`define WIN_INT_BASE      10'h080
`define WIN_DATA_PORT     10'h000
`define BURST_MAX         9'h100

// ****************************************************************
// Serial configuration memory framing and timing.
// ****************************************************************
`define MEM_BOOT_WORDS    3'h7
`define MEM_BLANK_WORD    16'hFFFF
`define MEM_CMD_BITS      5'h09
`define MEM_FRAME_BITS    5'h19
`define MEM_OP_READ       3'h6
`define MEM_OP_WRITE      3'h5
`define MEM_OP_EWEN       9'h130
`define CORE_CLK_MHZ      25
`define SCK_HALF_NS       500
`define SCK_HALF_CYC      ((`SCK_HALF_NS * `CORE_CLK_MHZ + 999) / 1000)

`endif

// >>> rtl/host_map_pkg.sv
// Types shared by the host register space map.
// Assumes the constants header sits beside this file.
package host_map_pkg;
  `include "host_map_consts.svh"

  // Serial engine states.
  typedef enum logic [1:0] {ST_IDLE, ST_FRAME, ST_GAP, ST_POLL} mem_state_t;

  // Operation the serial engine is carrying out.
  typedef enum logic [1:0] {OP_BOOT, OP_READ, OP_EWEN, OP_WRITE} mem_op_t;
endpackage

// >>> bench/host_map_sva.sv
// Checker of the host register space map, bound to the top module.
// Assumes core_clk and the synchronous active-low rstn of the design.
module host_map_sva (
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        cfg_req,
  input wire logic [7:0]  cfg_off,
  input wire logic        cfg_ack_ff,
  input wire logic [31:0] cfg_rdata_ff,
  input wire logic        mem_valid,
  input wire logic        mem_ack_ff,
  input wire logic        mem_miss_ff,
  input wire logic        fab_stb_ff,
  input wire logic        fab_global_ff,
  input wire logic [2:0]  fab_chan_ff,
  input wire logic [9:0]  fab_off_ff,
  input wire logic        cfg_mem_serial_clock,
  input wire logic        nv_busy_ff,
  input wire logic        nv_done_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Clocking and the steps of a memory beat.
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence s_beat;
    mem_valid;
  endsequence
  sequence s_beat_answer;
    ##2 mem_ack_ff;
  endsequence
  // ****************************************************************
  // Assertions.
  // ****************************************************************
  chk_cfg_answer: assert property (cfg_req |=> cfg_ack_ff)
    else $error("config answer missing");
  chk_beat_answer: assert property (s_beat |-> s_beat_answer)
    else $error("memory beat answer missing");
  chk_ack_cause: assert property (mem_ack_ff |-> $past(mem_valid, 2))
    else $error("memory answer without beat");
  chk_stb_cause: assert property (fab_stb_ff |-> $past(mem_valid))
    else $error("fabric strobe without beat");
  chk_miss_no_stb: assert property (mem_ack_ff && mem_miss_ff |-> !$past(fab_stb_ff))
    else $error("refused beat reached fabric");
  chk_global_map: assert property (fab_stb_ff && fab_global_ff |->
      fab_chan_ff == 3'h0 && fab_off_ff >= 10'h084)
    else $error("device-wide strobe outside its slice");
  chk_bar_low: assert property (cfg_ack_ff && $past(cfg_off) == 8'h10 |->
      cfg_rdata_ff[12:0] == 13'h0000)
    else $error("base address low bits not zero");
  chk_sck_high: assert property ($rose(cfg_mem_serial_clock) |=>
      cfg_mem_serial_clock [*8])
    else $error("serial clock high half too short");
  chk_done_pulse: assert property (nv_done_ff |-> $past(nv_busy_ff) ##1 !nv_done_ff)
    else $error("access done pulse malformed");
endmodule

bind host_register_space_map host_map_sva u_host_map_sva (.core_clk, .rstn, .cfg_req,
  .cfg_off, .cfg_ack_ff, .cfg_rdata_ff, .mem_valid, .mem_ack_ff, .mem_miss_ff,
  .fab_stb_ff, .fab_global_ff, .fab_chan_ff, .fab_off_ff, .cfg_mem_serial_clock,
  .nv_busy_ff, .nv_done_ff);

// >>> bench/cfg_mem_model.sv
// Behavioural serial configuration memory of 64 words of 16 bits.
// Assumes frames of start, two op bits, six address bits, data MSB first.
module cfg_mem_model (
  input wire logic cfg_mem_select,
  input wire logic cfg_mem_serial_clock,
  input wire logic cfg_mem_data_in,
  output logic     cfg_mem_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [64];  // Stored words.
  logic [24:0] sh;        // Bits shifted in this frame.
  logic [15:0] rw;        // Word being shifted out.
  int          cnt;       // Rising clocks seen in this frame.
  logic        rd;        // Read data phase active.
  logic        wen;       // Writes enabled.
  logic        busy;      // Internal write cycle running.
  logic        last;      // Last level driven while selected.
  // Preload a distinct pattern; word 0 is not blank, so IDs are overridden.
  initial begin
    for (int i = 0; i < 64; i++) mem[i] = 16'h0B00 + 16'h0111 * i[15:0];
    {cnt, rd, wen, busy, last, rw} = '0;
  end
  // A new frame starts on each select.
  always @(posedge cfg_mem_select) begin
    cnt = 0;
    rd = 0;
  end
  // Shift in on rising clock; decode read, enable and write frames.
  always @(posedge cfg_mem_serial_clock) if (cfg_mem_select) begin
    sh = {sh[23:0], cfg_mem_data_in};
    cnt++;
    if (cnt == 9 && sh[8:6] == 3'b110) begin
      rd = 1;
      rw = mem[sh[5:0]];
    end
    if (cnt == 9 && sh[8:4] == 5'b10011) wen = 1;
    if (cnt == 25 && sh[24:22] == 3'b101 && wen) begin
      mem[sh[21:16]] = sh[15:0];
      busy = 1;
    end
  end
  // Data bits change on the falling clock, ready for the next rise.
  always @(negedge cfg_mem_serial_clock) if (cfg_mem_select && rd) begin
    last = rw[15];
    rw = rw << 1;
  end
  // The internal write cycle lasts a few microseconds.
  always @(posedge busy) #3000 busy = 0;
  // Poll shows ready; when released the line shows the inverse of its last level.
  always @(cfg_mem_select or busy or rd) if (cfg_mem_select && !rd) last = !busy;
  assign cfg_mem_data_out = cfg_mem_select ? last : ~last;
endmodule

// >>> bench/host_register_space_map_tb.sv
// Self-checking bench of the host register space map.
// Assumes the memory model stands on the serial pins and a fabric answers bytes.
module host_register_space_map_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rstn, cfg_req, cfg_wr, cfg_ack_ff, mem_valid, mem_first, mem_wr;
  logic mem_ack_ff, mem_miss_ff, fab_stb_ff, fab_wr_ff, fab_global_ff, timer_irq;
  logic mpio_irq, wake_irq, nv_req, nv_wr, nv_busy_ff, nv_done_ff, cfg_mem_select;
  logic cfg_mem_serial_clock, cfg_mem_data_in, cfg_mem_data_out;
  logic [7:0]  cfg_off, mem_wdata, mem_rdata_ff, fab_wdata_ff, fab_rdata, chan_irq;
  logic [31:0] cfg_wdata, cfg_rdata_ff, mem_addr, rd;
  logic [2:0]  fab_chan_ff;
  logic [9:0]  fab_off_ff;
  logic [5:0]  nv_addr;
  logic [15:0] nv_wdata, nv_rdata_ff;
  logic [13:0] stb_q [$];  // Strobes seen: global, channel, offset.
  logic [8:0]  ack_q [$];  // Answers seen: miss, read byte.
  logic [8:0]  wr_q [$];   // Strobe kinds seen: write, write byte.
  int          miscompares, num_checks, cycles;
  localparam logic [31:0] BASE = 32'h8000_0000;  // Window base used.
  host_register_space_map u_host_register_space_map (.core_clk, .rstn, .cfg_req, .cfg_wr,
    .cfg_off, .cfg_wdata, .cfg_ack_ff, .cfg_rdata_ff, .mem_valid, .mem_first, .mem_wr,
    .mem_addr, .mem_wdata, .mem_ack_ff, .mem_miss_ff, .mem_rdata_ff, .fab_stb_ff,
    .fab_wr_ff, .fab_global_ff, .fab_chan_ff, .fab_off_ff, .fab_wdata_ff, .fab_rdata,
    .chan_irq, .timer_irq, .mpio_irq, .wake_irq, .nv_req, .nv_wr, .nv_addr, .nv_wdata,
    .nv_busy_ff, .nv_done_ff, .nv_rdata_ff, .cfg_mem_select, .cfg_mem_serial_clock,
    .cfg_mem_data_in, .cfg_mem_data_out);
  cfg_mem_model u_cfg_mem_model (.cfg_mem_select, .cfg_mem_serial_clock,
    .cfg_mem_data_in, .cfg_mem_data_out);
  // Fabric answers a byte made from offset and channel.
  assign fab_rdata = fab_off_ff[7:0] ^ {5'h00, fab_chan_ff};
  // Clock of 40 ns.
  initial begin
    core_clk = 0;
    forever #20 core_clk = ~core_clk;
  end
  // Record every strobe and every beat answer; bound the run.
  always @(posedge core_clk) begin
    if (fab_stb_ff === 1'b1) stb_q.push_back({fab_global_ff, fab_chan_ff, fab_off_ff});
    if (fab_stb_ff === 1'b1) wr_q.push_back({fab_wr_ff, fab_wdata_ff});
    if (mem_ack_ff === 1'b1) ack_q.push_back({mem_miss_ff, mem_rdata_ff});
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      test_done();
    end
  end
  function automatic logic [15:0] word(input int i);  // Preloaded memory word.
    return 16'h0B00 + 16'h0111 * i[15:0];
  endfunction
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One config request; the answer comes exactly one cycle after it is taken.
  task automatic cfg(input logic w, input logic [7:0] o, input logic [31:0] d);
    @(posedge core_clk);
    {cfg_req, cfg_wr, cfg_off, cfg_wdata} <= {1'b1, w, o, d};
    @(posedge core_clk) cfg_req <= 0;
    #1;
    chk_val(cfg_ack_ff, 1);
    rd = cfg_rdata_ff;
  endtask
  // A transaction of n back-to-back beats, then time for the answers.
  task automatic burst(input logic w, input logic [31:0] a, input int n);
    stb_q = {};
    ack_q = {};
    wr_q = {};
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      {mem_valid, mem_first, mem_wr, mem_addr, mem_wdata} <= {1'b1, i == 0, w, a, i[7:0]};
    end
    @(posedge core_clk) mem_valid <= 0;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic nv(input logic w, input logic [5:0] a, input logic [15:0] d);
    @(posedge core_clk);
    {nv_req, nv_wr, nv_addr, nv_wdata} <= {1'b1, w, a, d};
    @(posedge core_clk) nv_req <= 0;
    for (int i = 0; i < 8000 && nv_done_ff !== 1'b1; i++) @(posedge core_clk) #1;
    chk_val(nv_done_ff, 1);
  endtask
  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic t_boot_ids;
    for (int i = 0; i < 9000 && nv_busy_ff !== 1'b0; i++) @(posedge core_clk) #1;
    cfg(0, 8'h00, 0); chk_val(rd, {word(2), word(0)});
    cfg(0, 8'h2C, 0); chk_val(rd, {word(3), word(1)});
    cfg(0, 8'h08, 0); chk_val(rd, {word(4), 16'h0001} | 32'(word(5) & 16'hFF00));
    cfg(0, 8'h40, 0); chk_val(rd, {word(7), word(6)});
    cfg(0, 8'h0C, 0); chk_val(rd, 0);
  endtask
  task automatic t_bar;
    burst(0, 32'h0, 1); chk_val(ack_q[0][8], 1);
    cfg(1, 8'h10, 32'hFFFF_FFFF); cfg(0, 8'h10, 0); chk_val(rd, 32'hFFFF_E000);
    cfg(1, 8'h10, BASE); cfg(0, 8'h10, 0); chk_val(rd, BASE);
    cfg(1, 8'h04, 32'h2);
  endtask
  task automatic t_decode;
    for (int n = 0; n < 8; n++) begin
      burst(0, BASE + n * 32'h400 + 32'h5, 1);
      chk_val(stb_q[0], {1'b0, n[2:0], 10'h005});
      chk_val(ack_q[0], {1'b0, 8'h05 ^ n[7:0]});
    end
    burst(0, BASE + 32'h90, 1); chk_val(stb_q[0], {4'h8, 10'h090});
    burst(0, BASE + 32'h2000, 2); chk_val(ack_q[0][8], 1); chk_val(stb_q.size(), 0);
    chk_val(ack_q[1][8], 1);
  endtask
  task automatic t_irq;
    {chan_irq, timer_irq, mpio_irq, wake_irq} <= {8'hA5, 3'b101};
    burst(0, BASE + 32'h80, 4);
    chk_val(stb_q.size(), 0);
    chk_val(ack_q.size(), 4);
    foreach (ack_q[i]) chk_val(ack_q[i], i == 0 ? 9'h0A5 : i == 1 ? 9'h005 : 9'h000);
  endtask
  task automatic t_burst;
    burst(1, BASE + 32'h800, 257);
    chk_val(stb_q.size(), 256); chk_val(ack_q.size(), 257);
    foreach (stb_q[i]) chk_val(stb_q[i], {4'h2, 10'h000});
    foreach (wr_q[i]) chk_val(wr_q[i], {1'b1, i[7:0]});
    chk_val(ack_q[0], 9'h000);
    chk_val(ack_q[255][8], 0); chk_val(ack_q[256][8], 1);
    burst(0, BASE + 32'hC10, 3);
    foreach (stb_q[i]) chk_val(stb_q[i], {4'h3, 10'h010 + i[9:0]});
    foreach (ack_q[i]) chk_val(ack_q[i], {1'b0, (8'h10 + i[7:0]) ^ 8'h03});
    chk_val(wr_q[0][8], 0); chk_val(ack_q.size(), 3);
  endtask
  task automatic t_nv;
    nv(1, 6'h21, 16'hBEEF); nv(0, 6'h21, 0); chk_val(nv_rdata_ff, 16'hBEEF);
    nv(0, 6'h02, 0); chk_val(nv_rdata_ff, word(2));
  endtask
  task automatic test_done;
    if (miscompares == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Reset for 12 cycles, then the scenarios in order.
  initial begin
    {rstn, cfg_req, cfg_wr, cfg_off, cfg_wdata, mem_valid, mem_first, mem_wr} = '0;
    {mem_addr, mem_wdata, chan_irq, timer_irq, mpio_irq, wake_irq} = '0;
    {nv_req, nv_wr, nv_addr, nv_wdata} = '0;
    repeat (11) @(posedge core_clk);
    #1 chk_val(nv_busy_ff, 1);
    chk_val(cfg_mem_select, 1);
    @(posedge core_clk) rstn <= 1;
    t_boot_ids();
    t_bar();
    t_decode();
    t_irq();
    t_burst();
    t_nv();
    test_done();
  end
endmodule
